//--- rtl/ienf_pkg.sv
// register map, bit positions and reset values of the interrupt block
package ienf_pkg;
   // printed offsets are not all multiples of four: kept as indices
   localparam logic [8:0] ICTL_IDX0 = 9'h00B;
   localparam logic [8:0] ICTL_IDX1 = 9'h08B;
   localparam logic [8:0] ICTL_IDX2 = 9'h10B;
   localparam logic [8:0] ICTL_IDX3 = 9'h18B;
   localparam logic [8:0] PFLG_IDX = 9'h00C;
   localparam logic [8:0] PENA_IDX = 9'h08C;
   // block's own status/config register, index
   localparam logic [8:0] CFG_IDX = 9'h0F0;
   localparam int ADDR_W = 12;

   // core control bits
   localparam int B_GIE = 7;
   localparam int B_PERIPHERAL_GROUP_ENABLE = 6;
   localparam int B_T0IE = 5;
   localparam int B_EDGE_IE = 4;
   localparam int B_PCH_IE = 3;
   localparam int B_T0IF = 2;
   localparam int B_EDGE_IF = 1;
   localparam int B_PCH_IF = 0;

   // peripheral bits
   localparam int B_PAR = 7;
   localparam int B_ADC = 6;
   localparam int B_RX = 5;
   localparam int B_TX = 4;
   localparam int B_SSP = 3;
   localparam int B_CAPTURE_COMPARE_UNIT_1 = 2;
   localparam int B_TM2 = 1;
   localparam int B_TM1 = 0;

   localparam logic [7:0] ICTL_RST = 8'h00;
   localparam logic [7:0] PENA_RST = 8'h00;
   localparam logic [7:0] PFLG_RST = 8'h00;
   localparam logic [7:0] PFLG_RO_MASK = 8'h30;

   typedef enum logic [1:0] {ienf_ccp_capture, ienf_ccp_compare,
      ienf_ccp_pwm, ienf_ccp_off} ienf_ccp_mode_e;
endpackage : ienf_pkg

//--- rtl/ienf_sync.sv
// two-flop synchroniser for one level
`timescale 1ns/1ps
module ienf_sync
   import ienf_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic d,
   output logic q
);
   logic meta_r;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : ienf_sync

//--- rtl/ienf_flag.sv
// sticky flag: hardware set wins over software clear
`timescale 1ns/1ps
module ienf_flag
   import ienf_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic set,
   input wire logic wr,
   input wire logic wdata,
   output logic q
);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= 1'b0;
      end else if (set) begin
         q <= 1'b1;
      end else if (wr) begin
         q <= wdata;
      end
   end
endmodule : ienf_flag

//--- rtl/ienf_top.sv
// interrupt enable and flag logic with an AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// R1: global enable bit 7 clear blocks every interrupt request.
// R2: peripheral group enable bit 6 gates all peripheral sources.
// R3: flags set on their event whatever any enable holds.
// R4: software clears a flag before enabling its source.
// R5: core control register answers at all four bank offsets.
// R6: port-change flag sets on pins 7..4 change, software clears.
// R7: peripheral enable bits 7..0 per source, all reset to zero.
// R8: small package: software keeps parallel-port enable at zero.
// R9: small package: software keeps parallel-port flag at zero.
// R10: parallel-port access sets peripheral flag bit 7.
// R11: conversion done sets peripheral flag bit 6.
// R12: bit 5 is read-only, follows receive buffer full.
// R13: bit 4 is read-only, follows transmit buffer empty.
// R14: serial port transfer done sets its flag until cleared.
// R15: capture mode: capture event sets capture/compare flag bit 2.
// R16: compare mode: match sets capture/compare flag.
// R17: pwm mode never sets the capture/compare flag.
// R18: timer2 period match sets bit 1.
// R19: timer1 overflow sets bit 0.
// R20: request is global AND (core pairs OR group AND peripheral pairs).
// R21: bits 5..3 core enables, bits 2..1 timer0 and edge flags.
module ienf_top
   import ienf_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // event sources, one-cycle pulses from on-chip logic, plus the capture/compare mode level
   input wire logic timer0_overflow,
   input wire logic parallel_port_access,
   input wire logic conversion_done,
   input wire logic sync_serial_done,
   input wire logic capcomp1_capture,
   input wire logic capcomp1_match,
   input wire logic [1:0] capcomp1_mode,
   input wire logic timer2_match,
   input wire logic timer1_overflow,
   // buffer levels from the serial unit
   input wire logic serial_rx_full,
   input wire logic serial_tx_empty,
   // pins
   input wire logic external_edge_pin,
   input wire logic edge_rising,
   input wire logic [3:0] port_change_pins,
   output logic cpu_irq
);
   logic rst_meta_r, rst_n_r;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // pin synchronisers
   logic edge_s;
   logic [3:0] pins_s;
   ienf_sync u_sync_edge (
      .clock(clock),
      .resetn(rst_n_r),
      .d(external_edge_pin),
      .q(edge_s)
   );
   for (genvar i = 0; i < 4; i++) begin : g_psync
      ienf_sync u_sync (
         .clock(clock),
         .resetn(rst_n_r),
         .d(port_change_pins[i]),
         .q(pins_s[i])
      );
   end

   // history trusted only once the synchronisers hold pin values,
   // so a pin idling high gives no false event after reset
   logic edge_d_r;
   logic [3:0] pins_d_r;
   logic [2:0] pins_valid_r;
   logic hist_ok;
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         edge_d_r <= 1'b0;
         pins_d_r <= 4'h0;
         pins_valid_r <= 3'h0;
      end else begin
         edge_d_r <= edge_s;
         pins_d_r <= pins_s;
         pins_valid_r <= {pins_valid_r[1:0], 1'b1};
      end
   end
   assign hist_ok = pins_valid_r[2];
   logic edge_evt, pch_evt;
   assign edge_evt = hist_ok & (edge_rising ? (edge_s & ~edge_d_r)
                                            : (~edge_s & edge_d_r));
   assign pch_evt = hist_ok & (pins_s != pins_d_r); // [R6]

   // AXI write channel: address and data accepted in either order
   logic aw_held_r, w_held_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end else if (aw_held_r && w_held_r) begin
         aw_held_r <= 1'b0;
      end
   end
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (aw_held_r && w_held_r) begin
         w_held_r <= 1'b0;
      end
   end
   logic wr_go;
   assign wr_go = aw_held_r & w_held_r;

   function automatic logic [8:0] idx_of(input logic [ADDR_W-1:0] a);
      return a[10:2];
   endfunction : idx_of

   logic wr_lane0;
   logic [7:0] wd;
   logic [8:0] widx;
   assign wr_lane0 = wr_go & wstrb_r[0];
   assign wd = wdata_r[7:0];
   assign widx = idx_of(awaddr_r);
   logic wmapped, wr_ictl, wr_pflg, wr_pena;
   always_comb begin
      wr_ictl = 1'b0;
      wr_pflg = 1'b0;
      wr_pena = 1'b0;
      wmapped = 1'b1;
      if (awaddr_r[ADDR_W-1] || awaddr_r[1:0] != 2'b00) begin
         wmapped = 1'b0;
      end else if (widx == ICTL_IDX0 || widx == ICTL_IDX1 ||
                   widx == ICTL_IDX2 || widx == ICTL_IDX3) begin
         wr_ictl = wr_lane0; // [R5]
      end else if (widx == PFLG_IDX) begin
         wr_pflg = wr_lane0;
      end else if (widx == PENA_IDX) begin
         wr_pena = wr_lane0;
      end else if (widx == CFG_IDX) begin
         wmapped = 1'b1; // mode readback is read-only
      end else begin
         wmapped = 1'b0;
      end
   end

   // response one cycle after both halves are held
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wmapped ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // core control enables
   logic [7:3] ictl_en_r;
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ictl_en_r <= ICTL_RST[7:3];
      end else if (wr_ictl) begin
         ictl_en_r <= wd[7:3]; // [R21]
      end
   end

   logic [7:0] pena_r;
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pena_r <= PENA_RST; // [R7]
      end else if (wr_pena) begin
         pena_r <= wd; // [R7]
      end
   end

   // decode reads address bits 11..2: a narrower bus misses the banks
   if (ADDR_W < 12) begin : g_addr_chk
      $error("ienf_top needs ADDR_W of at least 12");
   end

   // core flags: timer0, edge pin, port change
   logic t0_f, edge_f, pch_f;
   ienf_flag u_f_t0 (
      .clock(clock),
      .rst_n(rst_n_r),
      .set(timer0_overflow), // [R3]
      .wr(wr_ictl),
      .wdata(wd[B_T0IF]), // [R21]
      .q(t0_f)
   );
   ienf_flag u_f_edge (
      .clock(clock),
      .rst_n(rst_n_r),
      .set(edge_evt),
      .wr(wr_ictl),
      .wdata(wd[B_EDGE_IF]), // [R21]
      .q(edge_f)
   );
   ienf_flag u_f_pch (
      .clock(clock),
      .rst_n(rst_n_r),
      .set(pch_evt), // [R6]
      .wr(wr_ictl),
      .wdata(wd[B_PCH_IF]),
      .q(pch_f)
   );

   // peripheral flag set events
   logic ccp_evt;
   always_comb begin
      case (ienf_ccp_mode_e'(capcomp1_mode))
         ienf_ccp_capture: ccp_evt = capcomp1_capture; // [R15]
         ienf_ccp_compare: ccp_evt = capcomp1_match; // [R16]
         default: ccp_evt = 1'b0; // [R17]
      endcase
   end
   logic [7:0] pset;
   assign pset = {parallel_port_access, conversion_done, 1'b0, 1'b0,
      sync_serial_done, ccp_evt, timer2_match, timer1_overflow};
   // [R10] [R11] [R14] [R18] [R19]
   logic [7:0] pflg;
   for (genvar b = 0; b < 8; b++) begin : g_pflg
      if (b == B_RX || b == B_TX) begin : g_ro
         assign pflg[b] = 1'b0;
      end else begin : g_rw
         ienf_flag u_f (
            .clock(clock),
            .rst_n(rst_n_r),
            .set(pset[b]), // [R3]
            .wr(wr_pflg),
            .wdata(wd[b]),
            .q(pflg[b])
         );
      end
   end
   logic [7:0] pflg_view;
   always_comb begin
      pflg_view = pflg & ~PFLG_RO_MASK;
      pflg_view[B_RX] = serial_rx_full; // [R12]
      pflg_view[B_TX] = serial_tx_empty; // [R13]
   end

   logic [7:0] ictl_view;
   assign ictl_view = {ictl_en_r, t0_f, edge_f, pch_f};

   // interrupt request
   logic core_hit, periph_hit;
   assign core_hit = (ictl_en_r[B_T0IE] & t0_f) |
                     (ictl_en_r[B_EDGE_IE] & edge_f) |
                     (ictl_en_r[B_PCH_IE] & pch_f);
   assign periph_hit = |(pflg_view & pena_r);
   // registered: follows a flag or enable change by one cycle
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cpu_irq <= 1'b0;
      end else begin
         cpu_irq <= ictl_en_r[B_GIE] & (core_hit |
            (ictl_en_r[B_PERIPHERAL_GROUP_ENABLE] & periph_hit)); // [R1] [R2] [R20]
      end
   end

   // read channel
   logic [8:0] ridx;
   logic [7:0] rbyte;
   logic rmapped;
   assign ridx = idx_of(s_axi_araddr);
   always_comb begin
      rbyte = 8'h00;
      rmapped = 1'b1;
      if (s_axi_araddr[ADDR_W-1] || s_axi_araddr[1:0] != 2'b00) begin
         rmapped = 1'b0;
      end else if (ridx == ICTL_IDX0 || ridx == ICTL_IDX1 ||
                   ridx == ICTL_IDX2 || ridx == ICTL_IDX3) begin
         rbyte = ictl_view; // [R5]
      end else if (ridx == PFLG_IDX) begin
         rbyte = pflg_view;
      end else if (ridx == PENA_IDX) begin
         rbyte = pena_r;
      end else if (ridx == CFG_IDX) begin
         rbyte = {6'h00, capcomp1_mode};
      end else begin
         rmapped = 1'b0;
      end
   end
   // one read in flight: a pending answer blocks the next address
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rbyte};
         s_axi_rresp <= rmapped ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : ienf_top

//--- bench/ienf_props.sv
// bus and flag checks on the interrupt block ports
`timescale 1ns/1ps
module ienf_props
   import ienf_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_rx_full,
   input wire logic serial_tx_empty
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   bresp_due_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   bresp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write response repeated");
   rresp_due_a: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read response missing");
   rresp_drop_a: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid) else $error("read response repeated");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while answer pending");
   rdata_upper_a: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
   live_bits_a: assert property (
      ar_taken ##0 s_axi_araddr == 12'h030 |=>
      s_axi_rdata[5] == $past(serial_rx_full) &&
      s_axi_rdata[4] == $past(serial_tx_empty))
      else $error("buffer flags not live");
   unmapped_err_a: assert property (ar_taken ##0 s_axi_araddr == 12'h004
      |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
endmodule : ienf_props
bind ienf_top ienf_props u_props (
   .clock(clock),
   .resetn(resetn),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .serial_rx_full(serial_rx_full),
   .serial_tx_empty(serial_tx_empty)
);

//--- bench/ienf_src_model.sv
// on-chip event sources: one-cycle pulses on request
`timescale 1ns/1ps
module ienf_src_model (
   input wire logic clock,
   input wire logic [7:0] req,
   output logic parallel_port_access,
   output logic conversion_done,
   output logic timer0_overflow,
   output logic capcomp1_match,
   output logic sync_serial_done,
   output logic capcomp1_capture,
   output logic timer2_match,
   output logic timer1_overflow
);
   logic [7:0] pulse_r;
   always_ff @(posedge clock) begin
      pulse_r <= req;
   end
   assign {parallel_port_access, conversion_done, timer0_overflow,
      capcomp1_match, sync_serial_done, capcomp1_capture, timer2_match,
      timer1_overflow} = pulse_r;
endmodule : ienf_src_model

//--- bench/tb_top.sv
// self-checking bench for the interrupt enable and flag block
`timescale 1ns/1ps
module tb_top;
   import ienf_pkg::*;
   logic clock = 1'h0;
   logic resetn = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv;
   logic [3:0] s_axi_wstrb = '0, port_change_pins = '0;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp, capcomp1_mode = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, edge_rising = 1'h1;
   logic serial_rx_full = 1'h0, serial_tx_empty = 1'h0;
   logic external_edge_pin = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, cpu_irq, parallel_port_access, conversion_done;
   logic timer0_overflow, capcomp1_match, sync_serial_done;
   logic capcomp1_capture, timer2_match, timer1_overflow;
   logic [7:0] req = '0;
   int fail_count = 0;
   int samples_checked = 0;
   ienf_top DUT (
      .clock(clock),
      .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .timer0_overflow(timer0_overflow),
      .parallel_port_access(parallel_port_access),
      .conversion_done(conversion_done),
      .sync_serial_done(sync_serial_done),
      .capcomp1_capture(capcomp1_capture),
      .capcomp1_match(capcomp1_match),
      .capcomp1_mode(capcomp1_mode),
      .timer2_match(timer2_match),
      .timer1_overflow(timer1_overflow),
      .serial_rx_full(serial_rx_full),
      .serial_tx_empty(serial_tx_empty),
      .external_edge_pin(external_edge_pin),
      .edge_rising(edge_rising),
      .port_change_pins(port_change_pins),
      .cpu_irq(cpu_irq)
   );
   ienf_src_model SRC (
      .clock(clock),
      .req(req),
      .parallel_port_access(parallel_port_access),
      .conversion_done(conversion_done),
      .timer0_overflow(timer0_overflow),
      .capcomp1_match(capcomp1_match),
      .sync_serial_done(sync_serial_done),
      .capcomp1_capture(capcomp1_capture),
      .timer2_match(timer2_match),
      .timer1_overflow(timer1_overflow)
   );
   initial forever #5 clock = ~clock;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      rdv = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk(rdv, e);
   endtask : rc
   task automatic fire(input logic [7:0] m);
      @(posedge clock);
      req <= m;
      @(posedge clock);
      req <= 8'h00;
      repeat (2) @(posedge clock);
   endtask : fire
   task automatic irq_is(input logic e);
      repeat (3) @(posedge clock);
      chk({31'h0, cpu_irq}, {31'h0, e});
   endtask : irq_is
   task automatic t_reset;
      rc(12'h02C, 32'h0);
      rc(12'h230, 32'h0);
      rc(12'h030, 32'h0);
      rd(12'h004);
      chk({30'h0, resp}, 32'h2);
      wr(12'h004, 8'hFF);
      chk({30'h0, resp}, 32'h2);
      $display("test reset done");
   endtask : t_reset
   task automatic t_banks;
      wr(12'h02C, 8'h38);
      chk({30'h0, resp}, 32'h0);
      rc(12'h22C, 32'h38);
      rc(12'h42C, 32'h38);
      rc(12'h62C, 32'h38);
      wr(12'h62C, 8'h00);
      rc(12'h02C, 32'h0);
      $display("test banks done");
   endtask : t_banks
   task automatic t_periph;
      logic [7:0] e;
      for (int i = 0; i < 8; i++) begin
         if (i == 5) continue;
         capcomp1_mode <= (i == 4) ? 2'h1 : 2'h0;
         e = (i == 4) ? 8'h04 : 8'h01 << i;
         fire(8'h01 << i);
         rc(12'h030, {24'h0, e});
         wr(12'h030, 8'h00);
         rc(12'h030, 32'h0);
      end
      capcomp1_mode <= 2'h2;
      fire(8'h14);
      rc(12'h030, 32'h0);
      rc(12'h3C0, 32'h2);
      capcomp1_mode <= 2'h3;
      fire(8'h14);
      rc(12'h030, 32'h0);
      rc(12'h3C0, 32'h3);
      $display("test peripheral flags done");
   endtask : t_periph
   task automatic t_live;
      serial_rx_full <= 1'h1;
      serial_tx_empty <= 1'h1;
      rc(12'h030, 32'h30);
      wr(12'h030, 8'h00);
      rc(12'h030, 32'h30);
      serial_rx_full <= 1'h0;
      rc(12'h030, 32'h10);
      serial_tx_empty <= 1'h0;
      rc(12'h030, 32'h0);
      $display("test buffer flags done");
   endtask : t_live
   task automatic t_core;
      port_change_pins <= 4'h8;
      external_edge_pin <= 1'h1;
      repeat (6) @(posedge clock);
      fire(8'h20);
      rc(12'h02C, 32'h07);
      wr(12'h02C, 8'h00);
      rc(12'h02C, 32'h0);
      edge_rising <= 1'h0;
      external_edge_pin <= 1'h0;
      port_change_pins <= 4'h0;
      repeat (6) @(posedge clock);
      rc(12'h02C, 32'h03);
      wr(12'h02C, 8'h00);
      $display("test core flags done");
   endtask : t_core
   task automatic t_irq;
      wr(12'h030, 8'h00);
      wr(12'h230, 8'h01);
      fire(8'h01);
      wr(12'h02C, 8'h40);
      irq_is(1'h0);
      wr(12'h02C, 8'h80);
      irq_is(1'h0);
      wr(12'h02C, 8'hC0);
      irq_is(1'h1);
      wr(12'h230, 8'h00);
      irq_is(1'h0);
      wr(12'h02C, 8'hA0);
      fire(8'h20);
      irq_is(1'h1);
      wr(12'h02C, 8'h24);
      irq_is(1'h0);
      $display("test request done");
   endtask : t_irq
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (16) @(posedge clock);
      resetn <= 1'h1;
      repeat (4) @(posedge clock);
      t_reset();
      t_banks();
      t_periph();
      t_live();
      t_core();
      t_irq();
      print_verdict();
   end
   initial begin
      #200us;
      fail_count++;
      print_verdict();
   end
endmodule : tb_top
